/* rtl/ttbu_core.sv */
// Notes on behaviour
// - 16-bit up/down counter, reload, prescaled
// - prescaler divides by 1 to 65536
// - divider buffered, applied at next update
// - count, reload, divider accessible while running
// - reload preload copied always or on update
// - counter advances only on gated tick
// - counting starts one cycle after enable
// - up: 0 to reload, wrap, overflow
// - down: reload to 0, reload, underflow
// - update after repeat count plus one wraps
// - update generate bit forces an update
// - update disable suppresses updates and transfers
// - up, disabled: still wraps, prescaler restarts
// - down, disabled: reloads active, prescaler restarts
// - request source hides flag for generate
// - update reloads repeat, reload, divider, flag
// - down update refreshes reload before counter
// - update generate bit reads as zero
// - repeat counter decrements on each wrap until zero
// - generated update ignores repeat counter, reloads
//
// Implementation choices: the AXI4-Lite register port and the register offsets.
`timescale 1ns/1ps
module ttbu_core (
   // clock and reset
   input  wire logic                        aclk,
   input  wire logic                        aresetn,
   // write address
   input  wire logic [ttbu_pkg::ADDR_W-1:0] s_axi_awaddr,
   input  wire logic [2:0]                  s_axi_awprot,
   input  wire logic                        s_axi_awvalid,
   output logic                             s_axi_awready,
   // write data
   input  wire logic [ttbu_pkg::DATA_W-1:0] s_axi_wdata,
   input  wire logic [3:0]                  s_axi_wstrb,
   input  wire logic                        s_axi_wvalid,
   output logic                             s_axi_wready,
   // write response
   output logic      [1:0]                  s_axi_bresp,
   output logic                             s_axi_bvalid,
   input  wire logic                        s_axi_bready,
   // read address
   input  wire logic [ttbu_pkg::ADDR_W-1:0] s_axi_araddr,
   input  wire logic [2:0]                  s_axi_arprot,
   input  wire logic                        s_axi_arvalid,
   output logic                             s_axi_arready,
   // read data
   output logic      [ttbu_pkg::DATA_W-1:0] s_axi_rdata,
   output logic      [1:0]                  s_axi_rresp,
   output logic                             s_axi_rvalid,
   input  wire logic                        s_axi_rready,
   // slave mode controller
   input  wire logic                        slave_update_generate,
   // timer state
   output logic                             update_event,
   output logic                             update_flag,
   output logic      [ttbu_pkg::CNT_W-1:0]  count_value
);
   import ttbu_pkg::*;

   // byte-lane merge of a 16-bit register
   function automatic logic [CNT_W-1:0] merge16(input logic [CNT_W-1:0]  old,
                                                input logic [DATA_W-1:0] wd,
                                                input logic [3:0]        be);
      merge16 = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
   endfunction
   // bus state
   logic              awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
   logic              aw_held_q, w_held_q;
   logic [ADDR_W-1:0] waddr_q;
   logic [DATA_W-1:0] wdata_q;
   logic [3:0]        wstrb_q;
   logic [1:0]        bresp_q, rresp_q, rresp_d;
   logic [DATA_W-1:0] rdata_q, rdata_d;
   // timer state
   logic              cen_q, update_disable_q, urs_q, dir_q, reload_preload_enable_q;
   logic              flag_q, flag_d, uev_q;
   logic [CNT_W-1:0]  cnt_q, cnt_d;
   logic [CNT_W-1:0]  arr_pre_q, arr_sh_q, psc_pre_q;
   logic [REP_W-1:0]  rcr_q, rep_q, rep_d;
   // decode
   wire               wr_fire   = aw_held_q && w_held_q && !bvalid_q;
   wire               ar_fire   = s_axi_arvalid && arready_q;
   wire               wr_ctrl   = wr_fire && (waddr_q == OFF_CONTROL_ONE);
   wire               wr_stat   = wr_fire && (waddr_q == OFF_STATUS_FLAGS);
   wire               wr_egr    = wr_fire && (waddr_q == OFF_EVENT_GENERATION);
   wire               wr_cnt    = wr_fire && (waddr_q == OFF_COUNT_VALUE);
   wire               wr_psc    = wr_fire && (waddr_q == OFF_DIVIDER_SETTING);
   wire               wr_arr    = wr_fire && (waddr_q == OFF_RELOAD_VALUE);
   wire               wr_rcr    = wr_fire && (waddr_q == OFF_REPEAT_COUNT);
   wire               wr_hit    = wr_ctrl || wr_stat || wr_egr || wr_cnt
                                  || wr_psc || wr_arr || wr_rcr;
   // timer datapath wires
   logic              tick;
   logic [CNT_W-1:0]  psc_count;
   logic [CNT_W-1:0]  div_act;
   wire               ug_sw     = wr_egr && wstrb_q[0] && wdata_q[BIT_UPDATE_GENERATE];
   wire               ug_any    = ug_sw || slave_update_generate;
   // direct path when preload is off
   wire [CNT_W-1:0]   arr_eff   = reload_preload_enable_q ? arr_sh_q : arr_pre_q;
   // up wrap at reload, down wrap at zero
   wire               wrap      = tick && (dir_q ? (cnt_q == '0) : (cnt_q == arr_eff));
   // hardware update only once repeat counter empty
   wire               hw_upd    = wrap && (rep_q == '0) && !update_disable_q;
   // generate bit; blocked by update disable
   wire               ug_upd    = ug_any && !update_disable_q;
   wire               upd       = hw_upd || ug_upd;
   // reload with fresh value on an update
   wire [CNT_W-1:0]   reload_v  = (upd || !reload_preload_enable_q) ? arr_pre_q : arr_sh_q;
   // prescaler runs from enable; generated update restarts it
   ttbu_prescaler u_prescaler (
      .aclk            (aclk),
      .aresetn         (aresetn),
      .run             (cen_q),
      .restart         (ug_upd),
      .load            (upd),
      .divider_preload (psc_pre_q),
      .counter_tick    (tick),
      .prescale_count  (psc_count),
      .divider_active  (div_act)
   );
   // write channel acceptance, either order
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_q <= 1'b0;
         w_held_q  <= 1'b0;
         awready_q <= 1'b1;
         wready_q  <= 1'b1;
         bvalid_q  <= 1'b0;
         bresp_q   <= RESP_OKAY;
         waddr_q   <= '0;
         wdata_q   <= '0;
         wstrb_q   <= '0;
      end else begin
         if (s_axi_awvalid && awready_q) begin
            aw_held_q <= 1'b1;
            awready_q <= 1'b0;
            waddr_q   <= s_axi_awaddr;
         end
         if (s_axi_wvalid && wready_q) begin
            w_held_q <= 1'b1;
            wready_q <= 1'b0;
            wdata_q  <= s_axi_wdata;
            wstrb_q  <= s_axi_wstrb;
         end
         if (wr_fire) begin
            aw_held_q <= 1'b0;
            w_held_q  <= 1'b0;
            bvalid_q  <= 1'b1;
            bresp_q   <= wr_hit ? RESP_OKAY : RESP_SLVERR;
         end
         if (bvalid_q && s_axi_bready) begin
            bvalid_q  <= 1'b0;
            awready_q <= 1'b1;
            wready_q  <= 1'b1;
         end
      end
   end
   // read mux
   always_comb begin
      rdata_d = '0;
      rresp_d = RESP_OKAY;
      if (s_axi_araddr == OFF_CONTROL_ONE) begin
         rdata_d[BIT_COUNT_ENABLE]          = cen_q;
         rdata_d[BIT_UPDATE_DISABLE]        = update_disable_q;
         rdata_d[BIT_UPDATE_REQUEST_SOURCE] = urs_q;
         rdata_d[BIT_DIRECTION_DOWN]        = dir_q;
         rdata_d[BIT_RELOAD_PRELOAD_ENABLE] = reload_preload_enable_q;
      end else if (s_axi_araddr == OFF_STATUS_FLAGS) begin
         rdata_d[BIT_UPDATE_FLAG] = flag_q;
      end else if (s_axi_araddr == OFF_EVENT_GENERATION) begin
         rdata_d = '0;
      end else if (s_axi_araddr == OFF_COUNT_VALUE) begin
         rdata_d[CNT_W-1:0] = cnt_q;
      end else if (s_axi_araddr == OFF_DIVIDER_SETTING) begin
         rdata_d[CNT_W-1:0] = psc_pre_q;
      end else if (s_axi_araddr == OFF_RELOAD_VALUE) begin
         rdata_d[CNT_W-1:0] = arr_pre_q;
      end else if (s_axi_araddr == OFF_REPEAT_COUNT) begin
         rdata_d[REP_W-1:0] = rcr_q;
      end else begin
         rresp_d = RESP_SLVERR;
      end
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready_q <= 1'b1;
         rvalid_q  <= 1'b0;
         rdata_q   <= '0;
         rresp_q   <= RESP_OKAY;
      end else if (ar_fire) begin
         arready_q <= 1'b0;
         rvalid_q  <= 1'b1;
         rdata_q   <= rdata_d;
         rresp_q   <= rresp_d;
      end else if (rvalid_q && s_axi_rready) begin
         arready_q <= 1'b1;
         rvalid_q  <= 1'b0;
      end
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cen_q     <= 1'b0;
         update_disable_q    <= 1'b0;
         urs_q     <= 1'b0;
         dir_q     <= 1'b0;
         reload_preload_enable_q    <= 1'b0;
         psc_pre_q <= RST_DIVIDER_SETTING;
         arr_pre_q <= RST_RELOAD_VALUE;
         rcr_q     <= RST_REPEAT_COUNT;
      end else begin
         if (wr_ctrl && wstrb_q[0]) begin
            cen_q  <= wdata_q[BIT_COUNT_ENABLE];
            update_disable_q <= wdata_q[BIT_UPDATE_DISABLE];
            urs_q  <= wdata_q[BIT_UPDATE_REQUEST_SOURCE];
            dir_q  <= wdata_q[BIT_DIRECTION_DOWN];
            reload_preload_enable_q <= wdata_q[BIT_RELOAD_PRELOAD_ENABLE];
         end
         if (wr_psc) begin
            psc_pre_q <= merge16(psc_pre_q, wdata_q, wstrb_q);
         end
         if (wr_arr) begin
            arr_pre_q <= merge16(arr_pre_q, wdata_q, wstrb_q);
         end
         if (wr_rcr && wstrb_q[0]) begin
            rcr_q <= wdata_q[REP_W-1:0];
         end
      end
   end
   // counter next value, up or down
   always_comb begin
      cnt_d = cnt_q;
      if (wr_cnt) begin
         cnt_d = merge16(cnt_q, wdata_q, wstrb_q);
      end else if (ug_upd || wrap) begin
         // up wraps to 0; down reloads
         cnt_d = dir_q ? reload_v : '0;
      end else if (tick) begin
         cnt_d = dir_q ? cnt_q - 16'h0001 : cnt_q + 16'h0001;
      end
   end
   // repetition counter next value
   always_comb begin
      rep_d = rep_q;
      if (upd) begin
         rep_d = rcr_q;
      end else if (wrap && rep_q != '0) begin
         rep_d = rep_q - 8'h01;
      end
   end
   // flag: set wins over clear
   always_comb begin
      flag_d = flag_q;
      if (wr_stat && wstrb_q[0] && !wdata_q[BIT_UPDATE_FLAG]) begin
         flag_d = 1'b0;
      end
      // generated update hidden when request source set
      if (hw_upd || (ug_upd && !urs_q)) begin
         flag_d = 1'b1;
      end
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cnt_q    <= RST_COUNT_VALUE;
         rep_q    <= RST_REPEAT_COUNT;
         arr_sh_q <= RST_RELOAD_VALUE;
         flag_q   <= 1'b0;
         uev_q    <= 1'b0;
      end else begin
         cnt_q  <= cnt_d;
         rep_q  <= rep_d;
         flag_q <= flag_d;
         uev_q  <= upd;
         if (upd || !reload_preload_enable_q) begin
            arr_sh_q <= arr_pre_q;
         end
      end
   end
   assign s_axi_awready = awready_q;
   assign s_axi_wready  = wready_q;
   assign s_axi_bvalid  = bvalid_q;
   assign s_axi_bresp   = bresp_q;
   assign s_axi_arready = arready_q;
   assign s_axi_rvalid  = rvalid_q;
   assign s_axi_rdata   = rdata_q;
   assign s_axi_rresp   = rresp_q;
   assign update_event  = uev_q;
   assign update_flag   = flag_q;
   assign count_value   = cnt_q;

   // checks
   wire quiet = !wr_fire && !ug_any;
   sequence s_enable;
      wr_ctrl && wstrb_q[0] && wdata_q[BIT_COUNT_ENABLE] && !cen_q
      && psc_count == '0 && div_act == '0 && !slave_update_generate;
   endsequence
   sequence s_up_top;
      quiet && !dir_q && tick && cnt_q == arr_eff;
   endsequence
   sequence s_down_bottom;
      quiet && dir_q && tick && cnt_q == '0;
   endsequence

   a_up_wrap_zero: assert property (@(posedge aclk) disable iff (!aresetn)
      s_up_top |=> cnt_q == '0) else $error("up counter did not wrap to zero");
   a_up_step_one: assert property (@(posedge aclk) disable iff (!aresetn)
      (quiet && !dir_q && tick && cnt_q != arr_eff) |=> cnt_q == $past(cnt_q) + 16'h0001)
      else $error("up counter step wrong");
   a_down_reload_new: assert property (@(posedge aclk) disable iff (!aresetn)
      s_down_bottom |=> cnt_q == arr_eff) else $error("down counter reload wrong");
   a_hold_no_tick: assert property (@(posedge aclk) disable iff (!aresetn)
      (quiet && !tick) |=> $stable(cnt_q)) else $error("counter moved without tick");
   a_start_one_cycle: assert property (@(posedge aclk) disable iff (!aresetn)
      s_enable |=> tick) else $error("count did not start one cycle after enable");
   a_disable_blocks: assert property (@(posedge aclk) disable iff (!aresetn)
      update_disable_q |-> ##1 (!uev_q && $stable(div_act))) else $error("update while disabled");
   a_urs_no_flag: assert property (@(posedge aclk) disable iff (!aresetn)
      (ug_upd && urs_q && !hw_upd && !flag_q) |=> !flag_q)
      else $error("flag set by generated update");
   a_update_sets_flag: assert property (@(posedge aclk) disable iff (!aresetn)
      hw_upd |=> flag_q && update_event) else $error("update did not set flag");
   a_repeat_reload: assert property (@(posedge aclk) disable iff (!aresetn)
      upd |=> rep_q == $past(rcr_q)) else $error("repeat counter not reloaded");
   a_repeat_count: assert property (@(posedge aclk) disable iff (!aresetn)
      (wrap && !upd && rep_q != '0) |=> rep_q == $past(rep_q) - 8'h01 && !update_event)
      else $error("repeat counter step wrong");
   a_divider_hold: assert property (@(posedge aclk) disable iff (!aresetn)
      !upd |=> div_act == $past(div_act)) else $error("divider changed without update");
endmodule

/* rtl/ttbu_pkg.sv */
package ttbu_pkg;
   // data widths
   localparam int unsigned CNT_W  = 16;
   localparam int unsigned REP_W  = 8;
   localparam int unsigned ADDR_W = 8;
   localparam int unsigned DATA_W = 32;

   // register byte offsets
   localparam logic [ADDR_W-1:0] OFF_CONTROL_ONE      = 8'h00;
   localparam logic [ADDR_W-1:0] OFF_STATUS_FLAGS     = 8'h04;
   localparam logic [ADDR_W-1:0] OFF_EVENT_GENERATION = 8'h08;
   localparam logic [ADDR_W-1:0] OFF_COUNT_VALUE      = 8'h0C;
   localparam logic [ADDR_W-1:0] OFF_DIVIDER_SETTING  = 8'h10;
   localparam logic [ADDR_W-1:0] OFF_RELOAD_VALUE     = 8'h14;
   localparam logic [ADDR_W-1:0] OFF_REPEAT_COUNT     = 8'h18;

   // control_one field positions
   localparam int unsigned BIT_COUNT_ENABLE          = 0;
   localparam int unsigned BIT_UPDATE_DISABLE        = 1;
   localparam int unsigned BIT_UPDATE_REQUEST_SOURCE = 2;
   localparam int unsigned BIT_DIRECTION_DOWN        = 4;
   localparam int unsigned BIT_RELOAD_PRELOAD_ENABLE = 7;

   // status_flags and event_generation field positions
   localparam int unsigned BIT_UPDATE_FLAG     = 0;
   localparam int unsigned BIT_UPDATE_GENERATE = 0;

   // reset values
   localparam logic [CNT_W-1:0] RST_COUNT_VALUE     = 16'h0000;
   localparam logic [CNT_W-1:0] RST_DIVIDER_SETTING = 16'h0000;
   localparam logic [CNT_W-1:0] RST_RELOAD_VALUE    = 16'hFFFF;
   localparam logic [REP_W-1:0] RST_REPEAT_COUNT    = 8'h00;

   // bus responses
   localparam logic [1:0] RESP_OKAY   = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage

/* rtl/ttbu_prescaler.sv */
`timescale 1ns/1ps
module ttbu_prescaler (
   // clock and reset
   input  wire logic                      aclk,
   input  wire logic                      aresetn,
   // control
   input  wire logic                      run,
   input  wire logic                      restart,
   input  wire logic                      load,
   input  wire logic [ttbu_pkg::CNT_W-1:0] divider_preload,
   // status
   output logic                           counter_tick,
   output logic      [ttbu_pkg::CNT_W-1:0] prescale_count,
   output logic      [ttbu_pkg::CNT_W-1:0] divider_active
);
   import ttbu_pkg::*;

   logic [CNT_W-1:0] psc_q;
   logic [CNT_W-1:0] psc_d;
   logic [CNT_W-1:0] div_q;

   assign counter_tick   = run && (psc_q == div_q);
   assign prescale_count = psc_q;
   assign divider_active = div_q;

   // count toward divider, wrap on tick
   assign psc_d = (restart || counter_tick) ? '0
                : run ? psc_q + 16'h0001 : psc_q;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         psc_q <= '0;
      end else begin
         psc_q <= psc_d;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         div_q <= RST_DIVIDER_SETTING;
      end else if (load) begin
         div_q <= divider_preload;
      end
   end
endmodule

/* sim/timer_time_base_unit_bench.sv */
`timescale 1ns/1ps
module timer_time_base_unit_bench;
   import ttbu_pkg::*;
   localparam logic [31:0] EN = 32'h1 << BIT_COUNT_ENABLE;
   localparam logic [31:0] UD = 32'h1 << BIT_UPDATE_DISABLE;
   localparam logic [31:0] RS = 32'h1 << BIT_UPDATE_REQUEST_SOURCE;
   localparam logic [31:0] DN = 32'h1 << BIT_DIRECTION_DOWN;
   localparam logic [31:0] PE = 32'h1 << BIT_RELOAD_PRELOAD_ENABLE;
   logic              aclk = 1'b0;
   logic              aresetn = 1'b0;
   logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
   logic              awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0;
   logic              rready = 1'b0, slave_ug = 1'b0;
   logic [DATA_W-1:0] wdata = '0, rdata;
   logic [1:0]        bresp, rresp;
   logic              awready, wready, bvalid, arready, rvalid;
   logic              update_event, update_flag;
   logic [CNT_W-1:0]  count_value;
   int                mismatches = 0;
   int                compares = 0;

   ttbu_core dut (
      .aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .slave_update_generate(slave_ug),
      .update_event(update_event), .update_flag(update_flag), .count_value(count_value)
   );

   initial begin
      forever #2.5 aclk = ~aclk;
   end

   task automatic conclude();
      if (mismatches == 0 && compares > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         mismatches++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      bit done;
      done = 0;
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!done) begin
         @(posedge aclk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid === 1'b1) begin
            r = bresp;
            bready <= 1'b0;
            done = 1;
         end
      end
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      bit done;
      done = 0;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      while (!done) begin
         @(posedge aclk);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid === 1'b1) begin
            d = rdata;
            r = rresp;
            rready <= 1'b0;
            done = 1;
         end
      end
   endtask

   // write with an okay response expected
   task automatic w(input logic [7:0] a, input logic [31:0] d);
      logic [1:0] r;
      wr(a, d, r);
      chk(32'(r), 32'(RESP_OKAY));
   endtask

   // read and compare data and response
   task automatic rc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
      logic [31:0] d;
      logic [1:0]  r;
      rd(a, d, r);
      chk(d, e);
      chk(32'(r), 32'(er));
   endtask

   // edges until an update pulse; 0 if none within lim
   task automatic wait_ue(input int lim, output int n);
      n = 0;
      do begin
         @(posedge aclk);
         n++;
      end while (update_event !== 1'b1 && n < lim);
      if (update_event !== 1'b1) n = 0;
   endtask

   task automatic per(input int e);
      int n;
      wait_ue(200, n);
      wait_ue(200, n);
      chk(32'(n), 32'(e));
   endtask

   // every edge the counter takes one step of its mode
   task automatic steps(input logic dn, input logic [15:0] rl);
      logic [15:0] prev, exp;
      int          i;
      @(posedge aclk);
      prev = count_value;
      for (i = 0; i < 8; i++) begin
         @(posedge aclk);
         if (dn) exp = (prev == 16'h0000) ? rl : prev - 16'h0001;
         else exp = (prev == rl) ? 16'h0000 : prev + 16'h0001;
         chk(32'(count_value), 32'(exp));
         prev = count_value;
      end
   endtask

   task automatic t_reset();
      logic [1:0]  r;
      rc(OFF_CONTROL_ONE, 32'h0, RESP_OKAY);
      rc(OFF_STATUS_FLAGS, 32'h0, RESP_OKAY);
      rc(OFF_COUNT_VALUE, 32'h0, RESP_OKAY);
      rc(OFF_DIVIDER_SETTING, 32'(RST_DIVIDER_SETTING), RESP_OKAY);
      rc(OFF_RELOAD_VALUE, 32'(RST_RELOAD_VALUE), RESP_OKAY);
      rc(OFF_REPEAT_COUNT, 32'(RST_REPEAT_COUNT), RESP_OKAY);
      rc(8'h1C, 32'h0, RESP_SLVERR);
      wr(8'h1C, 32'h5, r);
      chk(32'(r), 32'(RESP_SLVERR));
      w(OFF_COUNT_VALUE, 32'h1234);
      rc(OFF_COUNT_VALUE, 32'h1234, RESP_OKAY);
      w(OFF_COUNT_VALUE, 32'h0);
   endtask

   task automatic t_up();
      w(OFF_RELOAD_VALUE, 32'h3);
      w(OFF_CONTROL_ONE, EN);
      steps(1'b0, 16'h0003);
      per(4);
      w(OFF_DIVIDER_SETTING, 32'h1);
      rc(OFF_DIVIDER_SETTING, 32'h1, RESP_OKAY);
      per(8);
      w(OFF_EVENT_GENERATION, 32'h1);
      per(8);
      w(OFF_REPEAT_COUNT, 32'h2);
      w(OFF_EVENT_GENERATION, 32'h1);
      per(24);
      w(OFF_DIVIDER_SETTING, 32'h0);
      w(OFF_REPEAT_COUNT, 32'h0);
      w(OFF_EVENT_GENERATION, 32'h1);
      per(4);
   endtask

   task automatic t_down();
      w(OFF_CONTROL_ONE, EN | DN);
      steps(1'b1, 16'h0003);
      w(OFF_CONTROL_ONE, EN | DN | PE);
      w(OFF_RELOAD_VALUE, 32'h5);
      per(6);
      w(OFF_CONTROL_ONE, EN);
      w(OFF_RELOAD_VALUE, 32'h9);
      per(10);
   endtask

   task automatic t_update_disable();
      int n;
      w(OFF_CONTROL_ONE, EN | UD);
      w(OFF_RELOAD_VALUE, 32'h3);
      w(OFF_COUNT_VALUE, 32'h0);
      wait_ue(40, n);
      chk(32'(n), 32'h0);
      w(OFF_DIVIDER_SETTING, 32'h1);
      steps(1'b0, 16'h0003);
      w(OFF_CONTROL_ONE, EN | UD | DN);
      steps(1'b1, 16'h0003);
      w(OFF_EVENT_GENERATION, 32'h1);
      wait_ue(20, n);
      chk(32'(n), 32'h0);
   endtask

   task automatic t_gen();
      int n;
      w(OFF_CONTROL_ONE, 32'h0);
      w(OFF_STATUS_FLAGS, 32'h0);
      rc(OFF_STATUS_FLAGS, 32'h0, RESP_OKAY);
      w(OFF_CONTROL_ONE, RS);
      fork
         w(OFF_EVENT_GENERATION, 32'h1);
         wait_ue(20, n);
      join
      chk(32'(n != 0), 32'h1);
      rc(OFF_STATUS_FLAGS, 32'h0, RESP_OKAY);
      chk(32'(update_flag), 32'h0);
      rc(OFF_EVENT_GENERATION, 32'h0, RESP_OKAY);
      w(OFF_CONTROL_ONE, 32'h0);
      @(posedge aclk);
      slave_ug <= 1'b1;
      @(posedge aclk);
      slave_ug <= 1'b0;
      wait_ue(10, n);
      chk(32'(n != 0), 32'h1);
      rc(OFF_STATUS_FLAGS, 32'h1, RESP_OKAY);
      chk(32'(update_flag), 32'h1);
      w(OFF_STATUS_FLAGS, 32'h0);
      chk(32'(update_flag), 32'h0);
   endtask

   initial begin
      repeat (30000) @(posedge aclk);
      mismatches++;
      conclude();
   end

   initial begin
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      t_reset();
      t_up();
      t_down();
      t_update_disable();
      t_gen();
      conclude();
   end
endmodule
